// ===== pcm_highway_model.sv
// Behavioural far end of the highway: frame sync and bit clock
`timescale 1ns/100ps
`default_nettype none
module pcm_highway_model (
  input  wire logic        clk_sys_i, // System clock
  input  wire logic        go_i,      // Start one frame
  input  wire logic [10:0] bits_i,    // Bit clock rises in the frame
  output logic             bit_clk_o,          // Highway bit clock
  output logic             frame_sync_pulse_o, // Frame sync
  output logic             done_o              // Frame finished
);
  int n;
  // One process drives every output, so each has a single driver
  // Each level lasts four clocks, two more than the pin filter needs
  initial
  begin
    bit_clk_o          = 1'b0;
    frame_sync_pulse_o = 1'b0;
    done_o             = 1'b0;
    forever
    begin
      @(posedge clk_sys_i);
      if (go_i)
      begin
        #1;
        n                  = int'(bits_i);
        done_o             = 1'b0;
        frame_sync_pulse_o = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1;
        frame_sync_pulse_o = 1'b0;
        for (int i = 0; i < n; i++)
        begin
          repeat (4) @(posedge clk_sys_i);
          #1;
          bit_clk_o = 1'b1;
          repeat (4) @(posedge clk_sys_i);
          #1;
          bit_clk_o = 1'b0;
        end
        // Bit clock stands still low between frames
        repeat (4) @(posedge clk_sys_i);
        #1;
        done_o = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== pcm_rx_gain_map.svh
// Register offsets, field positions, reset value, gain limit and start count width
// Summary of operation
// - Receive capture starts after programmed bit-clock count
// - Start count is ten bits: high two, low byte
// - Transmit sign clear: larger magnitude means more gain
// - Transmit sign set: larger magnitude means more attenuation
// - Transmit step 1 dB, gain 12, attenuation 15
// - Transmit magnitude zero gives zero dB
// - Transmit sign clear, code 11xx gives 12 dB
// - Transmit sign set, code 1111 gives -15 dB
// - Receive sign clear: larger magnitude means more gain
// - Receive sign set: larger magnitude means more attenuation
// - Receive step 1 dB, gain 12, attenuation 15
// - Receive magnitude zero gives zero dB
// - Receive sign clear, code 11xx gives 12 dB
// - Receive sign set, code 1111 gives -15 dB
`ifndef PCM_RX_GAIN_MAP_SVH
`define PCM_RX_GAIN_MAP_SVH
`define RX_START_LOW_OFFSET   8'h24
`define RX_START_HIGH_OFFSET  8'h25
`define TX_GAIN2_OFFSET       8'h26
`define RX_GAIN2_OFFSET       8'h27
`define REG_RESET             8'h00
`define SIGN_BIT              4
`define MAG_MSB               3
`define START_HIGH_MSB        1
`define GAIN_MAX_DB           5'sh0c
`define START_COUNT_W         10
`endif

// ===== pcm_rx_gain_pkg.sv
// Types for the receive start count and stage two gain registers
package pcm_rx_gain_pkg;
  typedef enum logic [1:0] {
    RX_IDLE    = 2'b00,
    RX_WAIT    = 2'b01,
    RX_CAPTURE = 2'b10
  } rx_state_t;
  typedef logic signed [4:0] gain_db_t;
  typedef logic [9:0]        start_count_t;
endpackage

// ===== pcm_rx_gain_regs.sv
// Receive slot start counter and stage two gain control registers
`timescale 1ns/100ps
`include "pcm_rx_gain_map.svh"
`default_nettype none
module pcm_rx_gain_regs (
  input  wire logic       clk_sys_i,        // System clock, 125 MHz
  input  wire logic       rst_i,            // Synchronous reset, high
  input  wire logic [7:0] ctl_addr_i,       // Control port address
  input  wire logic [7:0] ctl_wdata_i,      // Control port write data
  input  wire logic       ctl_wr_i,         // Write strobe
  input  wire logic       ctl_rd_i,         // Read strobe
  output logic      [7:0] ctl_rdata_o,      // Read data, one cycle later
  output logic            ctl_rvalid_o,     // Read data valid pulse
  input  wire logic       pcm_bit_clk_i,    // Highway bit clock pin
  input  wire logic       frame_sync_pulse_i, // Frame sync pin
  output logic            rx_slot_active_o, // Receive capture window
  output logic      [4:0] tx_gain_db_o,     // Transmit gain, signed dB
  output logic      [4:0] rx_gain_db_o      // Receive gain, signed dB
);

  logic [7:0] start_low_q, start_low_d;
  logic [1:0] start_high_q, start_high_d;
  logic [4:0] tx_ctl_q, tx_ctl_d;
  logic [4:0] rx_ctl_q, rx_ctl_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;
  pcm_rx_gain_pkg::gain_db_t tx_gain_q, tx_gain_d;
  pcm_rx_gain_pkg::gain_db_t rx_gain_q, rx_gain_d;

  // Sign clear: up to +12 with 11xx saturating; sign set: down to -15
  function automatic pcm_rx_gain_pkg::gain_db_t gain_of(
    input logic       sign,
    input logic [3:0] mag
  );
    pcm_rx_gain_pkg::gain_db_t g;
    g = 5'sh00;
    if (mag == 4'h0)
      g = 5'sh00;
    else if (!sign && mag[3:2] == 2'b11)
      g = `GAIN_MAX_DB;
    else if (!sign)
      g = pcm_rx_gain_pkg::gain_db_t'({1'b0, mag});
    else
      g = -pcm_rx_gain_pkg::gain_db_t'({1'b0, mag});
    return g;
  endfunction

  always_comb
  begin
    start_low_d  = start_low_q;
    start_high_d = start_high_q;
    tx_ctl_d     = tx_ctl_q;
    rx_ctl_d     = rx_ctl_q;
    rdata_d      = rdata_q;
    rvalid_d     = ctl_rd_i;
    if (ctl_wr_i)
    begin
      case (ctl_addr_i)
        `RX_START_LOW_OFFSET:  start_low_d  = ctl_wdata_i;
        `RX_START_HIGH_OFFSET: start_high_d = ctl_wdata_i[`START_HIGH_MSB:0];
        `TX_GAIN2_OFFSET:      tx_ctl_d     = ctl_wdata_i[`SIGN_BIT:0];
        `RX_GAIN2_OFFSET:      rx_ctl_d     = ctl_wdata_i[`SIGN_BIT:0];
        default: ;
      endcase
    end
    if (ctl_rd_i)
    begin
      // Reserved bits and unmapped offsets read as zero
      case (ctl_addr_i)
        `RX_START_LOW_OFFSET:  rdata_d = start_low_q;
        `RX_START_HIGH_OFFSET: rdata_d = {6'h00, start_high_q};
        `TX_GAIN2_OFFSET:      rdata_d = {3'h0, tx_ctl_q};
        `RX_GAIN2_OFFSET:      rdata_d = {3'h0, rx_ctl_q};
        default:               rdata_d = 8'h00;
      endcase
    end
    tx_gain_d = gain_of(tx_ctl_q[`SIGN_BIT], tx_ctl_q[`MAG_MSB:0]);
    rx_gain_d = gain_of(rx_ctl_q[`SIGN_BIT], rx_ctl_q[`MAG_MSB:0]);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      start_low_q  <= `REG_RESET;
      start_high_q <= 2'h0;
      tx_ctl_q     <= 5'h00;
      rx_ctl_q     <= 5'h00;
      rdata_q      <= 8'h00;
      rvalid_q     <= 1'b0;
      tx_gain_q    <= 5'sh00;
      rx_gain_q    <= 5'sh00;
    end
    else
    begin
      start_low_q  <= start_low_d;
      start_high_q <= start_high_d;
      tx_ctl_q     <= tx_ctl_d;
      rx_ctl_q     <= rx_ctl_d;
      rdata_q      <= rdata_d;
      rvalid_q     <= rvalid_d;
      tx_gain_q    <= tx_gain_d;
      rx_gain_q    <= rx_gain_d;
    end
  end

  // Pin synchronisers: a level is taken once stages two and three agree
  logic [2:0] clk_sync_q, clk_sync_d;
  logic [2:0] fs_sync_q, fs_sync_d;
  logic       clk_filt_q, clk_filt_d;
  logic       fs_filt_q, fs_filt_d;

  always_comb
  begin
    clk_sync_d = {clk_sync_q[1:0], pcm_bit_clk_i};
    fs_sync_d  = {fs_sync_q[1:0], frame_sync_pulse_i};
    clk_filt_d = (clk_sync_q[1] == clk_sync_q[2]) ? clk_sync_q[2]
                                                  : clk_filt_q;
    fs_filt_d  = (fs_sync_q[1] == fs_sync_q[2]) ? fs_sync_q[2] : fs_filt_q;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      clk_sync_q <= 3'h0;
      fs_sync_q  <= 3'h0;
      clk_filt_q <= 1'b0;
      fs_filt_q  <= 1'b0;
    end
    else
    begin
      clk_sync_q <= clk_sync_d;
      fs_sync_q  <= fs_sync_d;
      clk_filt_q <= clk_filt_d;
      fs_filt_q  <= fs_filt_d;
    end
  end

  logic bit_edge;
  logic fs_edge;
  assign bit_edge = clk_filt_d & ~clk_filt_q;
  assign fs_edge  = fs_filt_d & ~fs_filt_q;

  // Capture window opens after the programmed number of bit clocks
  pcm_rx_gain_pkg::start_count_t start_count;
  pcm_rx_gain_pkg::start_count_t bit_cnt_q, bit_cnt_d;
  pcm_rx_gain_pkg::rx_state_t    state_q, state_d;
  logic                          active_q, active_d;
  assign start_count = {start_high_q, start_low_q};

  always_comb
  begin
    state_d   = state_q;
    bit_cnt_d = bit_cnt_q;
    if (fs_edge)
    begin
      // A new frame always restarts the count, even mid-capture
      bit_cnt_d = 10'h000;
      state_d   = (start_count == 10'h000) ? pcm_rx_gain_pkg::RX_CAPTURE
                                           : pcm_rx_gain_pkg::RX_WAIT;
    end
    else
    begin
      case (state_q)
        pcm_rx_gain_pkg::RX_IDLE: ;
        pcm_rx_gain_pkg::RX_WAIT:
          if (bit_edge)
          begin
            bit_cnt_d = bit_cnt_q + 10'h001;
            if (bit_cnt_d == start_count)
              state_d = pcm_rx_gain_pkg::RX_CAPTURE;
          end
        pcm_rx_gain_pkg::RX_CAPTURE: ;
        default: state_d = pcm_rx_gain_pkg::RX_IDLE;
      endcase
    end
    active_d = (state_d == pcm_rx_gain_pkg::RX_CAPTURE);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_q   <= pcm_rx_gain_pkg::RX_IDLE;
      bit_cnt_q <= 10'h000;
      active_q  <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      bit_cnt_q <= bit_cnt_d;
      active_q  <= active_d;
    end
  end

  assign ctl_rdata_o      = rdata_q;
  assign ctl_rvalid_o     = rvalid_q;
  assign rx_slot_active_o = active_q;
  assign tx_gain_db_o     = tx_gain_q;
  assign rx_gain_db_o     = rx_gain_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_high_reserved_zero;
    ctl_rd_i && ctl_addr_i == `RX_START_HIGH_OFFSET |=> rdata_q[7:2] == 6'h00;
  endproperty
  a_high_reserved_zero: assert property (p_high_reserved_zero)
    else $error("reserved bits of start count high read non-zero");

  property p_start_zero_capture;
    fs_edge && start_count == 10'h000 |=> active_q;
  endproperty
  a_start_zero_capture: assert property (p_start_zero_capture)
    else $error("capture did not open at frame sync for count zero");

  property p_wait_closed;
    fs_edge && start_count != 10'h000 |=> !active_q;
  endproperty
  a_wait_closed: assert property (p_wait_closed)
    else $error("capture opened before start count reached");

  property p_open_on_count;
    state_q == pcm_rx_gain_pkg::RX_CAPTURE
      && $past(state_q) == pcm_rx_gain_pkg::RX_WAIT
      |-> bit_cnt_q == start_count;
  endproperty
  a_open_on_count: assert property (p_open_on_count)
    else $error("capture opened at wrong bit count");

  property p_tx_zero;
    tx_ctl_q[3:0] == 4'h0 |=> tx_gain_q == 5'sh00;
  endproperty
  a_tx_zero: assert property (p_tx_zero)
    else $error("transmit magnitude zero gave non-zero gain");

  property p_tx_sat;
    !tx_ctl_q[4] && tx_ctl_q[3:2] == 2'b11 |=> tx_gain_q == 5'sh0c;
  endproperty
  a_tx_sat: assert property (p_tx_sat)
    else $error("transmit 11xx did not give 12 dB");

  property p_tx_atten;
    tx_ctl_q[4] |=> tx_gain_q == -$signed({1'b0, $past(tx_ctl_q[3:0])});
  endproperty
  a_tx_atten: assert property (p_tx_atten)
    else $error("transmit attenuation does not follow magnitude");

  property p_tx_gain;
    !tx_ctl_q[4] && tx_ctl_q[3:2] != 2'b11
      |=> tx_gain_q == $signed({1'b0, $past(tx_ctl_q[3:0])});
  endproperty
  a_tx_gain: assert property (p_tx_gain)
    else $error("transmit gain does not follow magnitude");

  property p_rx_zero;
    rx_ctl_q[3:0] == 4'h0 |=> rx_gain_q == 5'sh00;
  endproperty
  a_rx_zero: assert property (p_rx_zero)
    else $error("receive magnitude zero gave non-zero gain");

  property p_rx_sat;
    !rx_ctl_q[4] && rx_ctl_q[3:2] == 2'b11 |=> rx_gain_q == 5'sh0c;
  endproperty
  a_rx_sat: assert property (p_rx_sat)
    else $error("receive 11xx did not give 12 dB");

  property p_rx_full_atten;
    rx_ctl_q == 5'h1f |=> rx_gain_q == -5'sh0f;
  endproperty
  a_rx_full_atten: assert property (p_rx_full_atten)
    else $error("receive 1111 with sign did not give -15 dB");

  property p_rx_gain;
    !rx_ctl_q[4] && rx_ctl_q[3:2] != 2'b11
      |=> rx_gain_q == $signed({1'b0, $past(rx_ctl_q[3:0])});
  endproperty
  a_rx_gain: assert property (p_rx_gain)
    else $error("receive gain does not follow magnitude");

endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the start count and gain registers
`timescale 1ns/100ps
`include "pcm_rx_gain_map.svh"
`default_nettype none
`define CHK(act, exp, msg) \
  begin n_checks++; if ((act) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED at %0t: %s", $time, msg); end end
module testbench;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [7:0]  addr      = 8'h00;
  logic [7:0]  wdata     = 8'h00;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic        go        = 1'b0;
  logic [10:0] bits      = 11'h000;
  logic [7:0]  rdata;
  logic        rvalid, bclk, frame_sync_pulse, done, active;
  logic [4:0]  tx_db, rx_db;
  int          n_errors  = 0;
  int          n_checks  = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  pcm_rx_gain_regs DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .ctl_addr_i(addr), .ctl_wdata_i(wdata), .ctl_wr_i(wr), .ctl_rd_i(rd),
    .ctl_rdata_o(rdata), .ctl_rvalid_o(rvalid), .pcm_bit_clk_i(bclk),
    .frame_sync_pulse_i(frame_sync_pulse), .rx_slot_active_o(active),
    .tx_gain_db_o(tx_db), .rx_gain_db_o(rx_db));
  pcm_highway_model far_end (.clk_sys_i(clk_sys_i), .go_i(go),
    .bits_i(bits), .bit_clk_o(bclk),
    .frame_sync_pulse_o(frame_sync_pulse), .done_o(done));
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(posedge clk_sys_i);
    #1;
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    int i;
    @(posedge clk_sys_i);
    #1;
    addr = a;
    rd   = 1'b1;
    @(posedge clk_sys_i);
    #1;
    rd = 1'b0;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++) @(posedge clk_sys_i) #1;
    `CHK(rvalid, 1'b1, "no read answer")
    d = rdata;
    if (rvalid !== 1'b1) stop_test();
  endtask
  // Signed dB expected for a sign and magnitude code
  function automatic logic [4:0] exp_db(input logic [4:0] c);
    if (c[3:0] == 4'h0) return 5'h00;
    if (c[4]) return 5'h00 - {1'b0, c[3:0]};
    if (c[3:2] == 2'b11) return 5'h0c;
    return {1'b0, c[3:0]};
  endfunction
  task automatic frame(input logic [10:0] n);
    int i;
    @(posedge clk_sys_i);
    #1;
    bits = n;
    go   = 1'b1;
    @(posedge clk_sys_i);
    #1;
    go = 1'b0;
    @(posedge clk_sys_i);
    #1;
    for (i = 0; i < 20000 && done !== 1'b1; i++) @(posedge clk_sys_i) #1;
    `CHK(done, 1'b1, "frame never ended")
    if (done !== 1'b1) stop_test();
    repeat (8) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic test_regs();
    logic [7:0] d;
    `CHK({tx_db, rx_db, active}, 11'h000, "outputs after reset")
    for (int a = 8'h24; a < 8'h28; a++)
    begin
      rd_reg(a[7:0], d);
      `CHK(d, `REG_RESET, "reset value")
    end
    for (int a = 8'h24; a < 8'h28; a++) wr_reg(a[7:0], 8'hff);
    wr_reg(8'h30, 8'hff);
    rd_reg(`RX_START_LOW_OFFSET, d);
    `CHK(d, 8'hff, "low byte")
    rd_reg(`RX_START_HIGH_OFFSET, d);
    `CHK(d, 8'h03, "high bits")
    rd_reg(`TX_GAIN2_OFFSET, d);
    `CHK(d, 8'h1f, "tx gain reg")
    rd_reg(`RX_GAIN2_OFFSET, d);
    `CHK(d, 8'h1f, "rx gain reg")
    rd_reg(8'h30, d);
    `CHK(d, 8'h00, "unmapped read")
    $display("test_regs done");
  endtask
  task automatic test_gain();
    for (int c = 0; c < 32; c++)
    begin
      wr_reg(`TX_GAIN2_OFFSET, {3'h0, c[4:0]});
      wr_reg(`RX_GAIN2_OFFSET, {3'h0, ~c[4:0]});
      repeat (3) @(posedge clk_sys_i);
      #1;
      `CHK(tx_db, exp_db(c[4:0]), "tx gain")
      `CHK(rx_db, exp_db(~c[4:0]), "rx")
    end
    $display("test_gain done");
  endtask
  task automatic test_start();
    logic [9:0] n;
    for (int k = 0; k < 3; k++)
    begin
      n = (k == 0) ? 10'h000 : (k == 1) ? 10'h003 : 10'h100;
      wr_reg(`RX_START_LOW_OFFSET, n[7:0]);
      wr_reg(`RX_START_HIGH_OFFSET, {6'h00, n[9:8]});
      if (n != 10'h000)
      begin
        frame({1'b0, n} - 11'h001);
        `CHK(active, 1'b0, "window opened early")
      end
      frame({1'b0, n});
      `CHK(active, 1'b1, "window not open")
    end
    $display("test_start done");
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    test_regs();
    test_gain();
    test_start();
    stop_test();
  end
  initial
  begin
    #400000;
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
`default_nettype wire
